// ---- lac_loop_alarm_config_regs.sv ----
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - mode bit 1 set latches alarm until cleared; clear lets it self clear
// - mode bit 2 set opens assigned output on alarm; clear closes it
// - mode bit 5 enables the audible alarm while the alarm is active
// - mode bit 6 shuts the chamber down while the alarm is active
// - only mode bits 1, 2, 5, 6 act; other bits are stored only
// - alarm type picks off, process high/low/both, deviation high/low/both
// - route bits 0 to 14 each enable one event output, bit 15 is stored only; zero routes nowhere
// - high and low alarm setpoints are signed 16-bit tenths
// - hysteresis holds 0 to 32767 tenths only
// - loop 4 process value is read-only, tenths, unchanged by writes
// - loop 4 output percent is read-only, signed hundredths of a percent
// - autotune word reports off or active and takes start or stop requests
// - autotune codes: 0 off, 1 initiate, 2 active, 4 terminate
module lac_loop_alarm_config_regs #(
    parameter int unsigned EVENT_N = lac_pkg::EVENT_N
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [lac_pkg::ADDR_W-1:0] addr_in,
    input wire logic [lac_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [lac_pkg::DATA_W-1:0] loop3_measured_in,
    input wire logic [lac_pkg::DATA_W-1:0] loop3_target_in,
    input wire logic [lac_pkg::DATA_W-1:0] loop4_measured_in,
    input wire logic [lac_pkg::DATA_W-1:0] loop4_percent_in,
    input wire logic tune_active_in,
    output logic [lac_pkg::DATA_W-1:0] rdata_out,
    output logic [EVENT_N-1:0] event_out,
    output logic alarm_out,
    output logic audible_out,
    output logic shutdown_out,
    output logic loop4_target_out_unused_out,
    output logic [lac_pkg::DATA_W-1:0] loop4_target_out,
    output logic tune_start_out,
    output logic tune_stop_out
);
    typedef struct packed {
        logic [15:0] atype;
        logic [15:0] mode;
        logic [15:0] route;
        logic [15:0] high;
        logic [15:0] low;
        logic [15:0] hyst;
        logic [15:0] target;
        logic [15:0] measured;
        logic [15:0] percent;
        logic [15:0] tune;
        logic tune_prev;
        logic cond_high;
        logic cond_low;
        logic alarm;
        logic [EVENT_N-1:0] events;
        logic audible;
        logic shutdown;
        logic tune_start;
        logic tune_stop;
        logic [15:0] rdata;
    } lac_state_t;

    lac_state_t st_reg;
    lac_state_t st_next;

    function automatic logic hit(input logic [lac_pkg::ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [lac_pkg::CALC_W-1:0] sext(input logic [15:0] v);
        sext = {{(lac_pkg::CALC_W-16){v[15]}}, v};
    endfunction

    logic [lac_pkg::CALC_W-1:0] proc_val;
    logic [lac_pkg::CALC_W-1:0] dev_val;
    logic [lac_pkg::CALC_W-1:0] cmp_val;
    logic [lac_pkg::CALC_W-1:0] hi_lim;
    logic [lac_pkg::CALC_W-1:0] lo_lim;
    logic [lac_pkg::CALC_W-1:0] hy_val;
    logic use_high;
    logic use_low;
    logic is_dev;
    logic cond;
    logic clr;
    logic alarm_sense;

    always_comb begin
        st_next = st_reg;
        // measured and percent words track the loop, never the bus
        st_next.measured = loop4_measured_in;
        st_next.percent = loop4_percent_in;
        st_next.tune_prev = tune_active_in;
        st_next.tune_start = 1'b0;
        st_next.tune_stop = 1'b0;
        st_next.rdata = lac_pkg::RST_WORD;
        clr = 1'b0;

        if (wr_in) begin
            if (hit(addr_in, lac_pkg::OFS_ALARM_TYPE)) begin
                st_next.atype = wdata_in;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_MODE)) begin
                st_next.mode = wdata_in;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_ROUTE)) begin
                st_next.route = wdata_in;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_HIGH)) begin
                st_next.high = wdata_in;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_LOW)) begin
                st_next.low = wdata_in;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_HYST)) begin
                // a negative write is clamped to zero so the band never inverts
                st_next.hyst = wdata_in[lac_pkg::HYST_SIGN_BIT] ? lac_pkg::RST_WORD : wdata_in;
            end
            if (hit(addr_in, lac_pkg::OFS_L4_TARGET)) begin
                st_next.target = wdata_in;
            end
            if (hit(addr_in, lac_pkg::OFS_L4_TUNE)) begin
                st_next.tune = wdata_in;
                st_next.tune_start = (wdata_in == lac_pkg::TUNE_INIT);
                st_next.tune_stop = (wdata_in == lac_pkg::TUNE_TERM);
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_STATUS)) begin
                clr = wdata_in[lac_pkg::STAT_CLEAR_BIT];
            end
        end

        // autotune status follows the loop's own state changes
        if (tune_active_in && !st_reg.tune_prev) begin
            st_next.tune = lac_pkg::TUNE_ACTIVE;
        end else if (!tune_active_in && st_reg.tune_prev) begin
            st_next.tune = lac_pkg::TUNE_OFF;
        end

        // alarm detection in 18 bits so deviation and hysteresis cannot overflow
        proc_val = sext(loop3_measured_in);
        dev_val = proc_val - sext(loop3_target_in);
        hi_lim = sext(st_reg.high);
        lo_lim = sext(st_reg.low);
        hy_val = {2'b00, st_reg.hyst};
        use_high = 1'b0;
        use_low = 1'b0;
        is_dev = 1'b0;
        unique case (st_reg.atype[2:0])
            lac_pkg::ATYPE_OFF: begin
            end
            lac_pkg::ATYPE_PROC_HIGH: use_high = 1'b1;
            lac_pkg::ATYPE_PROC_LOW: use_low = 1'b1;
            lac_pkg::ATYPE_PROC_BOTH: begin
                use_high = 1'b1;
                use_low = 1'b1;
            end
            lac_pkg::ATYPE_DEV_HIGH: begin
                use_high = 1'b1;
                is_dev = 1'b1;
            end
            lac_pkg::ATYPE_DEV_LOW: begin
                use_low = 1'b1;
                is_dev = 1'b1;
            end
            lac_pkg::ATYPE_DEV_BOTH: begin
                use_high = 1'b1;
                use_low = 1'b1;
                is_dev = 1'b1;
            end
            default: begin
            end
        endcase
        // codes above six, or any upper bit set, read as alarm off
        if (st_reg.atype[15:3] != 13'h0000) begin
            use_high = 1'b0;
            use_low = 1'b0;
        end
        cmp_val = is_dev ? dev_val : proc_val;

        if (st_reg.cond_high) begin
            st_next.cond_high = use_high && ($signed(cmp_val) > $signed(hi_lim - hy_val));
        end else begin
            st_next.cond_high = use_high && ($signed(cmp_val) > $signed(hi_lim));
        end
        if (st_reg.cond_low) begin
            st_next.cond_low = use_low && ($signed(cmp_val) < $signed(lo_lim + hy_val));
        end else begin
            st_next.cond_low = use_low && ($signed(cmp_val) < $signed(lo_lim));
        end
        cond = st_next.cond_high | st_next.cond_low;

        // a condition present in the clearing cycle keeps the latch set
        if (st_reg.mode[lac_pkg::MODE_LATCH_BIT]) begin
            st_next.alarm = cond | (st_reg.alarm & ~clr);
        end else begin
            st_next.alarm = cond;
        end

        alarm_sense = st_reg.mode[lac_pkg::MODE_OPEN_BIT] ? ~st_next.alarm : st_next.alarm;
        for (int i = 0; i < EVENT_N; i++) begin
            st_next.events[i] = st_reg.route[i] & alarm_sense;
        end
        st_next.audible = st_next.alarm & st_reg.mode[lac_pkg::MODE_AUDIBLE_BIT];
        st_next.shutdown = st_next.alarm & st_reg.mode[lac_pkg::MODE_SHUTDOWN_BIT];

        if (rd_in) begin
            if (hit(addr_in, lac_pkg::OFS_ALARM_TYPE)) begin
                st_next.rdata = st_reg.atype;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_MODE)) begin
                st_next.rdata = st_reg.mode;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_ROUTE)) begin
                st_next.rdata = st_reg.route;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_HIGH)) begin
                st_next.rdata = st_reg.high;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_LOW)) begin
                st_next.rdata = st_reg.low;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_HYST)) begin
                st_next.rdata = st_reg.hyst;
            end
            if (hit(addr_in, lac_pkg::OFS_L4_TARGET)) begin
                st_next.rdata = st_reg.target;
            end
            if (hit(addr_in, lac_pkg::OFS_L4_MEASURED)) begin
                st_next.rdata = st_reg.measured;
            end
            if (hit(addr_in, lac_pkg::OFS_L4_PERCENT)) begin
                st_next.rdata = st_reg.percent;
            end
            if (hit(addr_in, lac_pkg::OFS_L4_TUNE)) begin
                st_next.rdata = st_reg.tune;
            end
            if (hit(addr_in, lac_pkg::OFS_ALARM_STATUS)) begin
                st_next.rdata[lac_pkg::STAT_ACTIVE_BIT] = st_reg.alarm;
                st_next.rdata[lac_pkg::STAT_COND_BIT] = st_reg.cond_high | st_reg.cond_low;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
            st_reg.tune <= lac_pkg::RST_TUNE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_out = st_reg.rdata;
    assign event_out = st_reg.events;
    assign alarm_out = st_reg.alarm;
    assign audible_out = st_reg.audible;
    assign shutdown_out = st_reg.shutdown;
    assign loop4_target_out = st_reg.target;
    assign loop4_target_out_unused_out = st_reg.tune_prev;
    assign tune_start_out = st_reg.tune_start;
    assign tune_stop_out = st_reg.tune_stop;
endmodule
`default_nettype wire

// ---- lac_pkg.sv ----
`default_nettype none
package lac_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned EVENT_N = 15;
    localparam int unsigned CALC_W = 18;

    // word offsets on the register port
    localparam logic [7:0] OFS_ALARM_TYPE = 8'h5a;
    localparam logic [7:0] OFS_ALARM_MODE = 8'h5b;
    localparam logic [7:0] OFS_ALARM_ROUTE = 8'h5c;
    localparam logic [7:0] OFS_ALARM_HIGH = 8'h5d;
    localparam logic [7:0] OFS_ALARM_LOW = 8'h5e;
    localparam logic [7:0] OFS_ALARM_HYST = 8'h5f;
    localparam logic [7:0] OFS_L4_TARGET = 8'h60;
    localparam logic [7:0] OFS_L4_MEASURED = 8'h61;
    localparam logic [7:0] OFS_L4_PERCENT = 8'h62;
    localparam logic [7:0] OFS_L4_TUNE = 8'h63;
    localparam logic [7:0] OFS_ALARM_STATUS = 8'h80;

    // alarm mode bit positions
    localparam int unsigned MODE_LATCH_BIT = 1;
    localparam int unsigned MODE_OPEN_BIT = 2;
    localparam int unsigned MODE_AUDIBLE_BIT = 5;
    localparam int unsigned MODE_SHUTDOWN_BIT = 6;

    // alarm status bit positions; writing 1 to the clear bit clears a latch
    localparam int unsigned STAT_ACTIVE_BIT = 0;
    localparam int unsigned STAT_COND_BIT = 1;
    localparam int unsigned STAT_CLEAR_BIT = 0;
    localparam int unsigned HYST_SIGN_BIT = 15;

    // autotune codes
    localparam logic [15:0] TUNE_OFF = 16'h0000;
    localparam logic [15:0] TUNE_INIT = 16'h0001;
    localparam logic [15:0] TUNE_ACTIVE = 16'h0002;
    localparam logic [15:0] TUNE_TERM = 16'h0004;

    // values after reset
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RST_TUNE = 16'h0000;

    typedef enum logic [2:0] {
        ATYPE_OFF = 3'h0,
        ATYPE_PROC_HIGH = 3'h1,
        ATYPE_PROC_LOW = 3'h2,
        ATYPE_PROC_BOTH = 3'h3,
        ATYPE_DEV_HIGH = 3'h4,
        ATYPE_DEV_LOW = 3'h5,
        ATYPE_DEV_BOTH = 3'h6
    } lac_atype_t;
endpackage
`default_nettype wire

// ---- lac_regs_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module lac_regs_sva #(
    parameter int unsigned EVENT_N = 15
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] loop3_measured_in,
    input wire logic [15:0] rdata_out,
    input wire logic [EVENT_N-1:0] event_out,
    input wire logic alarm_out,
    input wire logic audible_out,
    input wire logic shutdown_out,
    input wire logic [15:0] loop4_target_out,
    input wire logic tune_start_out,
    input wire logic tune_stop_out
);
    // shadow of the alarm words, fed from the bus only
    logic [15:0] cfg_q [0:5];
    logic cfg_wr;
    assign cfg_wr = wr_in && addr_in >= 8'h5a && addr_in <= 8'h5f;
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_q <= '{default: 16'h0000};
        end else if (cfg_wr) begin
            cfg_q[addr_in - 8'h5a] <= (addr_in == 8'h5f && wdata_in[15]) ? 16'h0000 : wdata_in;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // a config write needs one cycle before the outputs follow it
    ev_route_a: assert property (!$past(cfg_wr) |->
        event_out == (cfg_q[2][EVENT_N-1:0] & {EVENT_N{alarm_out ^ cfg_q[1][2]}})) else $error("event route");
    audible_a: assert property (!$past(cfg_wr) |-> audible_out == (alarm_out && cfg_q[1][5]))
        else $error("audible");
    shutdown_a: assert property (!$past(cfg_wr) |-> shutdown_out == (alarm_out && cfg_q[1][6]))
        else $error("shutdown");
    proc_high_a: assert property (!$past(cfg_wr) && cfg_q[0] == 16'h0001 && !cfg_q[1][1] && cfg_q[5] == 16'h0000
        |-> alarm_out == ($signed($past(loop3_measured_in)) > $signed(cfg_q[3]))) else $error("process high");
    latch_hold_a: assert property (alarm_out && cfg_q[1][1] && !cfg_wr && !(wr_in && addr_in == 8'h80)
        |=> alarm_out) else $error("latch dropped");
    rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000) else $error("rdata idle");
    tune_pulse_a: assert property ({tune_start_out, tune_stop_out} ==
        {$past(wr_in && addr_in == 8'h63 && wdata_in == 16'h0001), $past(wr_in && addr_in == 8'h63 && wdata_in == 16'h0004)})
        else $error("tune pulse");
    target_wr_a: assert property (wr_in && addr_in == 8'h60 |=> loop4_target_out == $past(wdata_in))
        else $error("target");
endmodule
bind lac_loop_alarm_config_regs lac_regs_sva #(.EVENT_N(EVENT_N)) chk_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .loop3_measured_in(loop3_measured_in),
    .rdata_out(rdata_out), .event_out(event_out), .alarm_out(alarm_out), .audible_out(audible_out),
    .shutdown_out(shutdown_out), .loop4_target_out(loop4_target_out), .tune_start_out(tune_start_out),
    .tune_stop_out(tune_stop_out));
`default_nettype wire

// ---- lac_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [15:0] loop3_measured_in = 16'h0000;
    logic [15:0] loop3_target_in = 16'h0032;
    logic [15:0] loop4_measured_in = 16'h0000;
    logic [15:0] loop4_percent_in = 16'h0000;
    logic tune_active_in = 1'b0;
    logic [15:0] rdata_out, loop4_target_out;
    logic [14:0] event_out;
    logic alarm_out, audible_out, shutdown_out, tune_start_out, tune_stop_out, a, tprev;
    int errors = 0;
    int cmp_count = 0;
    int i, t, k;
    int pvs[5] = '{151, 120, 0, -60, -200};
    int hv[3] = '{101, 96, 95};
    logic [15:0] ms[3] = '{16'h0000, 16'h0064, 16'hff99};
    logic [15:0] mdl [0:9];
    logic [15:0] r = 16'h005a;
    always #5 mclk_in = ~mclk_in;
    lac_loop_alarm_config_regs DUT (.mclk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .loop3_measured_in,
        .loop3_target_in, .loop4_measured_in, .loop4_percent_in, .tune_active_in, .rdata_out, .event_out, .alarm_out,
        .audible_out, .shutdown_out, .loop4_target_out_unused_out(tprev), .loop4_target_out, .tune_start_out,
        .tune_stop_out);
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // limits 100 and -100, deviation taken from a setpoint of 50
    function automatic logic ea(input int t, input int v);
        int d;
        d = (t >= 4 && t <= 6) ? v - 50 : v;
        return ((t == 1 || t == 3 || t == 4 || t == 6) && d > 100) || ((t == 2 || t == 3 || t == 5 || t == 6) && d < -100);
    endfunction
    task automatic complete_run;
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g, input string n);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bw(input logic [7:0] ad, input logic [15:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= ad;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic br(input logic [7:0] ad, input logic [15:0] e);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= ad;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 chk(e, rdata_out, "rdata");
    endtask
    task automatic settle(input logic [15:0] v);
        loop3_measured_in <= v;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask
    initial begin
        #400000;
        errors++;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge mclk_in);
        nrst_in <= 1'b1;
        for (i = 0; i < 11; i++) br(8'h5a + i[7:0], 16'h0000);
        r = nx(r);
        loop4_measured_in <= r;
        loop4_percent_in <= 16'hd8f0;
        for (i = 0; i < 10; i++) begin
            r = nx(r);
            mdl[i] = (i == 5 && r[15]) ? 16'h0000 : r;
            bw(8'h5a + i[7:0], r);
        end
        mdl[7] = loop4_measured_in;
        mdl[8] = 16'hd8f0;
        chk(mdl[6], loop4_target_out, "target");
        for (i = 0; i < 10; i++) br(8'h5a + i[7:0], mdl[i]);
        bw(8'h5f, 16'h8001);
        br(8'h5f, 16'h0000);
        bw(8'h5b, 16'h0000);
        bw(8'h5c, 16'h0000);
        bw(8'h5d, 16'h0064);
        bw(8'h5e, 16'hff9c);
        bw(8'h5f, 16'h0000);
        // type 7 is outside the table and must act as off
        for (t = 0; t < 8; t++) begin
            bw(8'h5a, t[15:0]);
            for (k = 0; k < 5; k++) begin
                settle(pvs[k][15:0]);
                chk({15'h0, ea(t, pvs[k])}, {15'h0, alarm_out}, "alarm");
            end
        end
        bw(8'h5a, 16'h0001);
        bw(8'h5c, 16'hc001);
        for (i = 0; i < 3; i++) begin
            bw(8'h5b, ms[i]);
            for (k = 0; k < 2; k++) begin
                a = k[0];
                settle(a ? 16'h0097 : 16'h0000);
                chk({1'b0, 15'h4001 & {15{a ^ ms[i][2]}}}, {1'b0, event_out}, "event");
                chk({15'h0, a & ms[i][5]}, {15'h0, audible_out}, "audible");
                chk({15'h0, a & ms[i][6]}, {15'h0, shutdown_out}, "shutdown");
            end
        end
        bw(8'h5b, 16'h0002);
        settle(16'h0097);
        bw(8'h80, 16'h0001);
        chk(16'h0001, {15'h0, alarm_out}, "latched");
        br(8'h80, 16'h0003);
        settle(16'h0000);
        chk(16'h0001, {15'h0, alarm_out}, "latched");
        br(8'h80, 16'h0001);
        bw(8'h80, 16'h0001);
        settle(16'h0000);
        chk(16'h0000, {15'h0, alarm_out}, "cleared");
        bw(8'h5b, 16'h0000);
        bw(8'h5f, 16'h0005);
        for (k = 0; k < 3; k++) begin
            settle(hv[k][15:0]);
            chk({15'h0, k < 2}, {15'h0, alarm_out}, "hysteresis");
        end
        bw(8'h63, 16'h0001);
        chk(16'h0001, {15'h0, tune_start_out}, "tune start");
        br(8'h63, 16'h0001);
        tune_active_in <= 1'b1;
        br(8'h63, 16'h0002);
        chk(16'h0001, {15'h0, tprev}, "tune level");
        tune_active_in <= 1'b0;
        br(8'h63, 16'h0000);
        bw(8'h63, 16'h0004);
        chk(16'h0001, {15'h0, tune_stop_out}, "tune stop");
        complete_run;
    end
endmodule
`default_nettype wire
